// ### core/mad_top.v
// Function
// RQ1 - Opposite limit during two/three-sensor homing: 61h
// RQ2 - One-way homing overrun or close sensors: 62h
// RQ3 - Three-sensor homing misses home sensor: 63h
// RQ4 - Timing and sensor_input_a unseen at home check: 64h
// RQ5 - Each home check disabled by zero bit
// RQ6 - Limit input with alarm stop action: 66h
// RQ7 - Setting 2 immediate, 3 decelerating stop
// RQ8 - Position reaches software limit: 67h
// RQ9 - Limit input during offset move: 6Ah
// RQ10 - Stored-data start with zero speed: 70h
// RQ11 - Consecutive frame errors reach limit: 84h
// RQ12 - Host silent past timeout: 85h
// RQ13 - Processor fault: F0h, steady LED, unclearable
// RQ14 - Excitation alarms keep motor current on
// RQ15 - Non-excitation alarms cut motor current
// RQ16 - Good frame zeroes error counter
// RQ17 - Latch code, hold alarm output until cleared
// RQ18 - Clear pulse clears clearable, vanished alarms
`timescale 1ns/1ps
`include "mad_map.vh"

module mad_top #(
  parameter BLINK_HALF = `MAD_BLINK_HALF_MS * `MAD_CLK_KHZ
) (
  input wire CLK_SYS_IN,
  input wire RESETN_IN,
  // AHB-Lite slave
  input wire HSEL_IN,
  input wire [31:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire [2:0] HSIZE_IN,
  input wire [31:0] HWDATA_IN,
  input wire HREADY_IN,
  output wire [31:0] HRDATA_OUT,
  output wire HREADYOUT_OUT,
  output wire HRESP_OUT,
  // Sensors and sequencer
  input wire FORWARD_LIMIT_INPUT_IN,
  input wire REVERSE_LIMIT_INPUT_IN,
  input wire HOME_SENSOR_INPUT_IN,
  input wire SENSOR_INPUT_A_IN,
  input wire STEP_TIMING_OUTPUT_IN,
  input wire ALARM_CLEAR_INPUT_IN,
  input wire HOMING_IN,
  input wire HOMING_DIR_FWD_IN,
  input wire HOME_OVERRUN_IN,
  input wire SENSORS_TOO_CLOSE_IN,
  input wire HOME_CHECK_IN,
  input wire OFFSET_MOVE_IN,
  input wire [31:0] POSITION_IN,
  input wire SD_START_IN,
  input wire [31:0] SD_SPEED_IN,
  input wire FRAME_OK_IN,
  input wire FRAME_ERR_IN,
  input wire CPU_FAULT_IN,
  // Alarm outputs
  output wire ALARM_OUT,
  output wire [7:0] ALARM_CODE_OUT,
  output wire MOTOR_EXCITE_OUT,
  output wire STOP_IMMEDIATE_OUT,
  output wire STOP_DECEL_OUT,
  output wire LED_OUT,
  output wire IRQ_OUT
);

  // ==============================================
  // Functions
  // True for the two alarm-producing stop settings
  function stop_alarm;
    input [1:0] act;
    begin
      stop_alarm = (act == `MAD_ACT_IMM) || (act == `MAD_ACT_DEC); // RQ7
    end
  endfunction

  // Excitation class; processor fault drops current for safety
  function keeps_exc;
    input [7:0] code;
    begin
      keeps_exc = (code != `MAD_A_CPU); // RQ14 RQ15
    end
  endfunction

  // ==============================================
  // Registers
  reg [31:0] ctrl_r; // Actions, homing mode, check enables
  reg [31:0] pos_lim_r; // Positive software limit
  reg [31:0] neg_lim_r; // Negative software limit
  reg [31:0] err_lim_r; // Error count that raises alarm
  reg [31:0] tmo_lim_r; // Timeout in cycles, zero disables
  reg [2:0] irq_st_r; // Sticky event bits
  reg [2:0] irq_en_r; // Event enables
  reg [31:0] hrdata_r;
  reg hreadyout_r;
  reg hresp_r;
  reg wr_pend_r; // Write data phase follows
  reg [7:0] wr_addr_r;
  reg alm_act_r; // Alarm latched
  reg [7:0] alm_code_r; // Latched code
  reg [7:0] alm_sub_r; // Latched sub code
  reg exc_r; // Motor current allowed
  reg stop_imm_r;
  reg stop_dec_r;
  reg led_r;
  reg irq_r;
  reg clr_q_r; // Previous clear input level
  reg seen_fwd_r; // Three-sensor travel history
  reg seen_rev_r;
  reg seen_home_r;
  reg tim_seen_r; // Home check history
  reg sensor_input_a_seen_r;
  reg [7:0] err_cnt_r; // Consecutive frame errors
  reg [31:0] tmo_cnt_r; // Cycles since last good frame
  reg [31:0] half_cnt_r; // LED half-period timer
  reg [4:0] phase_r; // LED half-period index

  // ==============================================
  // Trigger conditions
  wire [1:0] lim_act = ctrl_r[`MAD_CTRL_LIM_ACT];
  wire [1:0] soft_act = ctrl_r[`MAD_CTRL_SOFT_ACT];
  wire [1:0] mode = ctrl_r[`MAD_CTRL_MODE];
  wire any_lim = FORWARD_LIMIT_INPUT_IN | REVERSE_LIMIT_INPUT_IN;
  // Limit behind the direction of travel
  wire opp_lim = HOMING_DIR_FWD_IN ? REVERSE_LIMIT_INPUT_IN : FORWARD_LIMIT_INPUT_IN;
  wire tim_now = tim_seen_r | (HOME_SENSOR_INPUT_IN & STEP_TIMING_OUTPUT_IN);
  wire sensor_input_a_now = sensor_input_a_seen_r | (HOME_SENSOR_INPUT_IN & SENSOR_INPUT_A_IN);
  wire beyond = ($signed(POSITION_IN) >= $signed(pos_lim_r)) ||
                ($signed(POSITION_IN) <= $signed(neg_lim_r));
  wire [7:0] err_inc = err_cnt_r + 8'h01;

  wire t61 = HOMING_IN & opp_lim &
             ((mode == `MAD_MODE_TWO) || (mode == `MAD_MODE_THREE)); // RQ1
  wire t62 = HOMING_IN & (mode == `MAD_MODE_ONEWAY) &
             (HOME_OVERRUN_IN | SENSORS_TOO_CLOSE_IN); // RQ2
  wire t63 = HOMING_IN & (mode == `MAD_MODE_THREE) &
             seen_fwd_r & seen_rev_r & ~seen_home_r; // RQ3
  // A zero enable bit removes that signal from the check
  wire t64 = HOMING_IN & HOME_CHECK_IN &
             ((ctrl_r[`MAD_CTRL_TIM_EN] & ~tim_now) |
              (ctrl_r[`MAD_CTRL_SENSOR_INPUT_A_EN] & ~sensor_input_a_now)); // RQ4 RQ5
  wire t66 = stop_alarm(lim_act) & any_lim; // RQ6
  wire t67 = stop_alarm(soft_act) & beyond; // RQ8
  wire t6a = OFFSET_MOVE_IN & any_lim; // RQ9
  wire t70 = SD_START_IN & (SD_SPEED_IN == 32'h0000_0000); // RQ10
  wire t84 = FRAME_ERR_IN & ~FRAME_OK_IN & (err_lim_r[7:0] != 8'h00) &
             (err_inc >= err_lim_r[7:0]); // RQ11
  wire t85 = (tmo_lim_r != 32'h0000_0000) & (tmo_cnt_r >= tmo_lim_r); // RQ12

  // ==============================================
  // Priority pick of a new alarm
  reg [7:0] new_code;
  reg new_any;
  always @* begin
    new_any = 1'b1;
    if (t66) begin
      new_code = `MAD_A_HWOT;
    end else if (t67) begin
      new_code = `MAD_A_SWOT;
    end else if (t61) begin
      new_code = `MAD_A_REVLS;
    end else if (t62) begin
      new_code = `MAD_A_HOMEOP;
    end else if (t63) begin
      new_code = `MAD_A_NOHOME;
    end else if (t64) begin
      new_code = `MAD_A_TIMSLIT;
    end else if (t6a) begin
      new_code = `MAD_A_OFFSET;
    end else if (t70) begin
      new_code = `MAD_A_OPDATA;
    end else if (t84) begin
      new_code = `MAD_A_COMERR;
    end else if (t85) begin
      new_code = `MAD_A_COMTMO;
    end else begin
      new_code = 8'h00;
      new_any = 1'b0;
    end
  end

  // Cause of the latched alarm still present
  reg cond_now;
  always @* begin
    case (alm_code_r)
      `MAD_A_REVLS: cond_now = t61;
      `MAD_A_HOMEOP: cond_now = t62;
      `MAD_A_NOHOME: cond_now = t63;
      `MAD_A_HWOT: cond_now = t66;
      `MAD_A_SWOT: cond_now = t67;
      `MAD_A_OFFSET: cond_now = t6a;
      `MAD_A_COMTMO: cond_now = t85;
      default: cond_now = 1'b0;
    endcase
  end

  wire clr_edge = ALARM_CLEAR_INPUT_IN & ~clr_q_r;
  wire raise = CPU_FAULT_IN | (~alm_act_r & new_any);
  // Processor fault never clears; only power-up reset recovers
  wire clear = clr_edge & alm_act_r & (alm_code_r != `MAD_A_CPU) & ~cond_now; // RQ13 RQ18

  // ==============================================
  // Alarm latch and drive outputs
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      alm_act_r <= 1'b0;
      alm_code_r <= 8'h00;
      alm_sub_r <= 8'h00;
      exc_r <= 1'b1;
      clr_q_r <= 1'b0;
    end else begin
      clr_q_r <= ALARM_CLEAR_INPUT_IN;
      if (CPU_FAULT_IN) begin
        // Fault overrides whatever is latched
        alm_act_r <= 1'b1; // RQ13
        alm_code_r <= `MAD_A_CPU;
        alm_sub_r <= 8'h00;
        exc_r <= keeps_exc(`MAD_A_CPU); // RQ15
      end else if (raise) begin
        alm_act_r <= 1'b1; // RQ17
        alm_code_r <= new_code;
        alm_sub_r <= (new_code == `MAD_A_OPDATA) ? `MAD_SUB_SPEED0 : 8'h00; // RQ10
        exc_r <= keeps_exc(new_code); // RQ14
      end else if (clear) begin
        alm_act_r <= 1'b0; // RQ18
        alm_code_r <= 8'h00;
        alm_sub_r <= 8'h00;
        exc_r <= 1'b1;
      end
    end
  end

  // Stop requests follow the setting of the overtravel alarm
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stop_imm_r <= 1'b0;
      stop_dec_r <= 1'b0;
    end else begin
      stop_imm_r <= alm_act_r &
        (((alm_code_r == `MAD_A_HWOT) && (lim_act == `MAD_ACT_IMM)) ||
         ((alm_code_r == `MAD_A_SWOT) && (soft_act == `MAD_ACT_IMM))); // RQ7
      stop_dec_r <= alm_act_r &
        (((alm_code_r == `MAD_A_HWOT) && (lim_act == `MAD_ACT_DEC)) ||
         ((alm_code_r == `MAD_A_SWOT) && (soft_act == `MAD_ACT_DEC))); // RQ7
    end
  end

  // ==============================================
  // Homing history, cleared between homing runs
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      seen_fwd_r <= 1'b0;
      seen_rev_r <= 1'b0;
      seen_home_r <= 1'b0;
      tim_seen_r <= 1'b0;
      sensor_input_a_seen_r <= 1'b0;
    end else if (!HOMING_IN) begin
      seen_fwd_r <= 1'b0;
      seen_rev_r <= 1'b0;
      seen_home_r <= 1'b0;
      tim_seen_r <= 1'b0;
      sensor_input_a_seen_r <= 1'b0;
    end else begin
      seen_fwd_r <= seen_fwd_r | FORWARD_LIMIT_INPUT_IN; // RQ3
      seen_rev_r <= seen_rev_r | REVERSE_LIMIT_INPUT_IN;
      seen_home_r <= seen_home_r | HOME_SENSOR_INPUT_IN;
      tim_seen_r <= tim_now; // RQ4
      sensor_input_a_seen_r <= sensor_input_a_now;
    end
  end

  // ==============================================
  // Communication error counter and timeout
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      err_cnt_r <= 8'h00;
      tmo_cnt_r <= 32'h0000_0000;
    end else begin
      if (FRAME_OK_IN) begin
        err_cnt_r <= 8'h00; // RQ16
      end else if (FRAME_ERR_IN && err_cnt_r != 8'hFF) begin
        err_cnt_r <= err_inc; // RQ11
      end
      // Saturates so the timeout stays present until a frame lands
      if (FRAME_OK_IN || tmo_lim_r == 32'h0000_0000) begin
        tmo_cnt_r <= 32'h0000_0000;
      end else if (tmo_cnt_r < tmo_lim_r) begin
        tmo_cnt_r <= tmo_cnt_r + 32'h0000_0001; // RQ12
      end
    end
  end

  // ==============================================
  // LED: seven blinks then a pause, steady on processor fault
  wire half_end = (half_cnt_r >= BLINK_HALF - 1);
  wire [31:0] last_phase = 2 * `MAD_BLINK_N + `MAD_PAUSE_HALVES - 1;
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      half_cnt_r <= 32'h0000_0000;
      phase_r <= 5'h00;
      led_r <= 1'b0;
    end else if (!alm_act_r) begin
      half_cnt_r <= 32'h0000_0000;
      phase_r <= 5'h00;
      led_r <= 1'b0;
    end else begin
      if (half_end) begin
        half_cnt_r <= 32'h0000_0000;
        phase_r <= ({27'h000_0000, phase_r} == last_phase) ? 5'h00 : phase_r + 5'h01;
      end else begin
        half_cnt_r <= half_cnt_r + 32'h0000_0001;
      end
      if (alm_code_r == `MAD_A_CPU) begin
        led_r <= 1'b1; // RQ13
      end else begin
        led_r <= (phase_r < 2 * `MAD_BLINK_N) && !phase_r[0];
      end
    end
  end

  // ==============================================
  // AHB-Lite slave, zero wait states
  wire take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire wr_now = wr_pend_r;
  wire [2:0] irq_clr = (wr_now && wr_addr_r == `MAD_OFS_IRQ_CLR) ? HWDATA_IN[2:0] : 3'h0;
  wire [2:0] irq_set = {FRAME_ERR_IN, clear, raise};

  // Read mux for the address phase
  reg [31:0] rd_val;
  always @* begin
    case (HADDR_IN[7:0])
      `MAD_OFS_CTRL: rd_val = ctrl_r;
      `MAD_OFS_POS_LIM: rd_val = pos_lim_r;
      `MAD_OFS_NEG_LIM: rd_val = neg_lim_r;
      `MAD_OFS_ERR_LIM: rd_val = err_lim_r;
      `MAD_OFS_TMO_LIM: rd_val = tmo_lim_r;
      `MAD_OFS_STATUS: rd_val = {err_cnt_r, alm_sub_r, 6'h00, exc_r, alm_act_r, alm_code_r};
      `MAD_OFS_IRQ_ST: rd_val = {29'h0000_0000, irq_st_r};
      `MAD_OFS_IRQ_EN: rd_val = {29'h0000_0000, irq_en_r};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Bus phases and register writes
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      ctrl_r <= `MAD_CTRL_RST;
      pos_lim_r <= `MAD_POS_LIM_RST;
      neg_lim_r <= `MAD_NEG_LIM_RST;
      err_lim_r <= `MAD_ERR_LIM_RST;
      tmo_lim_r <= `MAD_TMO_LIM_RST;
      irq_en_r <= `MAD_IRQ_EN_RST;
    end else begin
      wr_pend_r <= take & HWRITE_IN;
      if (take) begin
        wr_addr_r <= HADDR_IN[7:0];
      end
      if (take && !HWRITE_IN) begin
        hrdata_r <= rd_val;
      end
      if (wr_now) begin
        case (wr_addr_r)
          `MAD_OFS_CTRL: ctrl_r <= {24'h00_0000, HWDATA_IN[7:0]};
          `MAD_OFS_POS_LIM: pos_lim_r <= HWDATA_IN;
          `MAD_OFS_NEG_LIM: neg_lim_r <= HWDATA_IN;
          `MAD_OFS_ERR_LIM: err_lim_r <= {24'h00_0000, HWDATA_IN[7:0]};
          `MAD_OFS_TMO_LIM: tmo_lim_r <= HWDATA_IN;
          `MAD_OFS_IRQ_EN: irq_en_r <= HWDATA_IN[2:0];
          default: hresp_r <= 1'b0;
        endcase
      end
    end
  end

  // ==============================================
  // Interrupt: set beats clear in the same cycle
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_st_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
      irq_r <= |(((irq_st_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  // ==============================================
  // Port drive
  assign HRDATA_OUT = hrdata_r;
  assign HREADYOUT_OUT = hreadyout_r;
  assign HRESP_OUT = hresp_r;
  assign ALARM_OUT = alm_act_r;
  assign ALARM_CODE_OUT = alm_code_r;
  assign MOTOR_EXCITE_OUT = exc_r;
  assign STOP_IMMEDIATE_OUT = stop_imm_r;
  assign STOP_DECEL_OUT = stop_dec_r;
  assign LED_OUT = led_r;
  assign IRQ_OUT = irq_r;

endmodule

// ### core/mad_map.vh
`ifndef MAD_MAP_VH
`define MAD_MAP_VH
// ==============================================
// Register byte offsets
`define MAD_OFS_CTRL 8'h00
`define MAD_OFS_POS_LIM 8'h04
`define MAD_OFS_NEG_LIM 8'h08
`define MAD_OFS_ERR_LIM 8'h0C
`define MAD_OFS_TMO_LIM 8'h10
`define MAD_OFS_STATUS 8'h14
`define MAD_OFS_IRQ_ST 8'h18
`define MAD_OFS_IRQ_CLR 8'h1C
`define MAD_OFS_IRQ_EN 8'h20
// ==============================================
// Control field positions
`define MAD_CTRL_LIM_ACT 1:0
`define MAD_CTRL_SOFT_ACT 3:2
`define MAD_CTRL_MODE 5:4
`define MAD_CTRL_TIM_EN 6
`define MAD_CTRL_SENSOR_INPUT_A_EN 7
// Status field positions
`define MAD_ST_CODE 7:0
`define MAD_ST_ACTIVE 8
`define MAD_ST_EXCITE 9
`define MAD_ST_SUB 23:16
`define MAD_ST_ERRCNT 31:24
// Interrupt bits
`define MAD_IRQ_RAISE 0
`define MAD_IRQ_CLEAR 1
`define MAD_IRQ_COMM 2
// ==============================================
// Reset values
`define MAD_CTRL_RST 32'h0000_00C0
`define MAD_POS_LIM_RST 32'h7FFF_FFFF
`define MAD_NEG_LIM_RST 32'h8000_0000
`define MAD_ERR_LIM_RST 32'h0000_0003
`define MAD_TMO_LIM_RST 32'h0000_0000
`define MAD_IRQ_EN_RST 3'h0
// ==============================================
// Setting values
`define MAD_ACT_IMM 2'h2
`define MAD_ACT_DEC 2'h3
`define MAD_MODE_TWO 2'h0
`define MAD_MODE_THREE 2'h1
`define MAD_MODE_ONEWAY 2'h2
// ==============================================
// Alarm codes and sub code
`define MAD_A_REVLS 8'h61
`define MAD_A_HOMEOP 8'h62
`define MAD_A_NOHOME 8'h63
`define MAD_A_TIMSLIT 8'h64
`define MAD_A_HWOT 8'h66
`define MAD_A_SWOT 8'h67
`define MAD_A_OFFSET 8'h6A
`define MAD_A_OPDATA 8'h70
`define MAD_A_COMERR 8'h84
`define MAD_A_COMTMO 8'h85
`define MAD_A_CPU 8'hF0
`define MAD_SUB_SPEED0 8'h01
// ==============================================
// LED timing
`define MAD_BLINK_N 7
`define MAD_BLINK_HALF_MS 200
`define MAD_PAUSE_HALVES 4
`define MAD_CLK_KHZ 100000
`endif

// ### dv/mad_top_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Alarm latch checker
module mad_top_asserts (
  input wire CLK_SYS_IN,
  input wire RESETN_IN,
  input wire FORWARD_LIMIT_INPUT_IN,
  input wire REVERSE_LIMIT_INPUT_IN,
  input wire ALARM_CLEAR_INPUT_IN,
  input wire HOMING_IN,
  input wire SD_START_IN,
  input wire [31:0] SD_SPEED_IN,
  input wire FRAME_ERR_IN,
  input wire CPU_FAULT_IN,
  input wire ALARM_OUT,
  input wire [7:0] ALARM_CODE_OUT,
  input wire MOTOR_EXCITE_OUT,
  input wire LED_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  // Either limit sensor active
  wire lim = FORWARD_LIMIT_INPUT_IN | REVERSE_LIMIT_INPUT_IN;
  // Code of the latched alarm
  wire [7:0] c = ALARM_CODE_OUT;
  a_cpu_fault: assert property (
    CPU_FAULT_IN |=> ALARM_OUT && c == 8'hF0) else $error("fault not latched");
  a_f0_sticky: assert property (
    c == 8'hF0 |=> c == 8'hF0) else $error("processor alarm left");
  a_f0_led_on: assert property (
    c == 8'hF0 [*2] |-> LED_OUT) else $error("led not steady");
  a_f0_no_current: assert property (
    c == 8'hF0 |-> !MOTOR_EXCITE_OUT) else $error("current kept on fault");
  a_excite_kept: assert property (
    ALARM_OUT && c != 8'hF0 |-> MOTOR_EXCITE_OUT) else $error("current cut");
  a_code_flag: assert property (
    ALARM_OUT == (c != 8'h00)) else $error("flag and code disagree");
  // Without a clear the latch must stand
  a_alarm_holds: assert property (
    ALARM_OUT && !ALARM_CLEAR_INPUT_IN && !$past(ALARM_CLEAR_INPUT_IN) |=> ALARM_OUT)
    else $error("alarm dropped");
  a_limit_cause: assert property (
    $rose(ALARM_OUT) && (c == 8'h66 || c == 8'h6A) |-> $past(lim))
    else $error("limit alarm without limit");
  a_home_cause: assert property (
    $rose(ALARM_OUT) && c inside {8'h61, 8'h62, 8'h63, 8'h64} |-> $past(HOMING_IN))
    else $error("homing alarm outside homing");
  a_speed_cause: assert property (
    $rose(ALARM_OUT) && c == 8'h70 |-> $past(SD_START_IN && SD_SPEED_IN == 0))
    else $error("data alarm without zero speed");
  a_comm_cause: assert property (
    $rose(ALARM_OUT) && c == 8'h84 |-> $past(FRAME_ERR_IN)) else $error("no frame error");
  // Level checked cause still present refuses the clear
  a_limit_refuse: assert property (
    ALARM_OUT && c == 8'h66 && lim |=> ALARM_OUT) else $error("cleared with limit on");
  c_hw: cover property ($rose(ALARM_OUT) && c == 8'h66);
  c_cpu: cover property ($rose(ALARM_OUT) && c == 8'hF0);
  c_comm: cover property ($rose(ALARM_OUT) && c == 8'h84);
  c_clear: cover property ($fell(ALARM_OUT));
endmodule

bind mad_top mad_top_asserts u_chk (.CLK_SYS_IN, .RESETN_IN, .FORWARD_LIMIT_INPUT_IN,
  .REVERSE_LIMIT_INPUT_IN, .ALARM_CLEAR_INPUT_IN, .HOMING_IN, .SD_START_IN, .SD_SPEED_IN,
  .FRAME_ERR_IN, .CPU_FAULT_IN, .ALARM_OUT, .ALARM_CODE_OUT, .MOTOR_EXCITE_OUT, .LED_OUT);

// ### dv/mad_host_link.sv
`timescale 1ns/1ps
// ==========================================
// Host link: one frame verdict per request
module mad_host_link (
  input wire clk_in,
  input wire resetn_in,
  input wire [1:0] req_in,
  output reg frame_ok_out,
  output reg frame_err_out
);
  // Registered so each verdict is a clean one-cycle pulse
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_ok_out <= 1'b0;
      frame_err_out <= 1'b0;
    end else begin
      frame_ok_out <= (req_in == 2'd1);
      frame_err_out <= (req_in == 2'd2);
    end
  end
endmodule

// ### dv/mad_top_test.sv
`timescale 1ns/1ps
// ==========================================
// Alarm block bench
module mad_top_test;
  reg clk, rst_n, ok, hw, fl, rl, hs, sa, st, clr, hm, dir, ovr, cls, chk, ofs, sds, cpu;
  reg [1:0] htr, lreq;
  reg [31:0] ha, hwd, pos, spd, v;
  wire fok, ferr, hrdy, hresp, alm, exc, simm, sdec, led, irq;
  wire [31:0] hrd;
  wire [7:0] code;
  integer n_mismatch, n_compared, i, j, k, n, lp;
  mad_top #(.BLINK_HALF(4)) DUT (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(1'b1),
    .HADDR_IN(ha), .HTRANS_IN(htr), .HWRITE_IN(hw), .HSIZE_IN(3'h2), .HWDATA_IN(hwd),
    .HREADY_IN(hrdy), .HRDATA_OUT(hrd), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .FORWARD_LIMIT_INPUT_IN(fl), .REVERSE_LIMIT_INPUT_IN(rl), .HOME_SENSOR_INPUT_IN(hs),
    .SENSOR_INPUT_A_IN(sa), .STEP_TIMING_OUTPUT_IN(st), .ALARM_CLEAR_INPUT_IN(clr),
    .HOMING_IN(hm), .HOMING_DIR_FWD_IN(dir), .HOME_OVERRUN_IN(ovr),
    .SENSORS_TOO_CLOSE_IN(cls), .HOME_CHECK_IN(chk), .OFFSET_MOVE_IN(ofs),
    .POSITION_IN(pos), .SD_START_IN(sds), .SD_SPEED_IN(spd), .FRAME_OK_IN(fok),
    .FRAME_ERR_IN(ferr), .CPU_FAULT_IN(cpu), .ALARM_OUT(alm), .ALARM_CODE_OUT(code),
    .MOTOR_EXCITE_OUT(exc), .STOP_IMMEDIATE_OUT(simm), .STOP_DECEL_OUT(sdec),
    .LED_OUT(led), .IRQ_OUT(irq));
  mad_host_link u_host (.clk_in(clk), .resetn_in(rst_n), .req_in(lreq),
    .frame_ok_out(fok), .frame_err_out(ferr));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // Shared tasks
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Settle past the edge so registered outputs have landed
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // Ready and read data taken as the coming edge will see them
  task rdy;
    begin
      k = 0;
      do begin
        ok = hrdy;
        v = hrd;
        tick;
        k = k + 1;
      end while (ok !== 1'b1 && k < 20);
      if (ok !== 1'b1) begin
        cmp(0, 1);
        end_sim;
      end
    end
  endtask
  // One AHB single transfer; read data kept in v
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      htr <= 2'b10;
      ha <= {24'h0000_00, a};
      hw <= w;
      rdy;
      htr <= 2'b00;
      hwd <= d;
      rdy;
      cmp(hresp, 0);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      ahb(0, a, 0);
      cmp(v, e);
    end
  endtask
  // Bounded wait for a latch, then its code
  task walm(input [7:0] e);
    begin
      k = 0;
      while (alm !== 1'b1 && k < 60) begin
        tick;
        k = k + 1;
      end
      if (alm !== 1'b1) begin
        cmp(0, 1);
        end_sim;
      end
      cmp(code, e);
    end
  endtask
  task clear;
    begin
      clr <= 1;
      repeat (2) tick;
      clr <= 0;
      repeat (2) tick;
    end
  endtask
  task frame(input [1:0] r);
    begin
      lreq <= r;
      tick;
      lreq <= 0;
      repeat (2) tick;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    cmp(0, 1);
    end_sim;
  end
  // ==========================================
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_n = 0;
    {hw, fl, rl, hs, sa, st, clr, hm, dir, ovr, cls, chk, ofs, sds, cpu} = 0;
    htr = 0;
    lreq = 0;
    ha = 0;
    hwd = 0;
    pos = 0;
    spd = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    tick;
    rd(8'h00, 32'h0000_00C0);
    rd(8'h04, 32'h7FFF_FFFF);
    rd(8'h08, 32'h8000_0000);
    rd(8'h0C, 32'h0000_0003);
    rd(8'h10, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    $display("test registers done");
    for (i = 2; i < 4; i = i + 1) begin
      ahb(1, 8'h00, i);
      fl <= (i == 2);
      rl <= (i == 3);
      walm(8'h66);
      tick;
      cmp({simm, sdec}, (i == 2) ? 2'b10 : 2'b01);
      n = 0;
      // One full period of 18 halves holds exactly seven rises
      for (j = 0; j < 72; j = j + 1) begin
        lp = led;
        tick;
        if (led === 1'b1 && lp == 0) n = n + 1;
      end
      cmp(n, 7);
      clear;
      cmp(alm, 1);
      fl <= 0;
      rl <= 0;
      clear;
      cmp({alm, code}, 0);
    end
    $display("test limit done");
    ahb(1, 8'h04, 100);
    // Both alarm-producing soft-limit settings
    for (i = 2; i < 4; i = i + 1) begin
      ahb(1, 8'h00, i << 2);
      pos <= 100;
      walm(8'h67);
      tick;
      cmp({simm, sdec}, (i == 2) ? 2'b10 : 2'b01);
      pos <= 0;
      clear;
      cmp(alm, 0);
    end
    $display("test soft limit done");
    ahb(1, 8'h00, 0);
    hm <= 1;
    dir <= 1;
    rl <= 1;
    walm(8'h61);
    rl <= 0;
    hm <= 0;
    clear;
    ahb(1, 8'h00, 32'h0000_0020);
    for (j = 0; j < 2; j = j + 1) begin
      hm <= 1;
      ovr <= (j == 0);
      cls <= (j == 1);
      walm(8'h62);
      {hm, ovr, cls} <= 0;
      clear;
      cmp(alm, 0);
    end
    ahb(1, 8'h00, 32'h0000_0010);
    hm <= 1;
    fl <= 1;
    tick;
    fl <= 0;
    dir <= 0;
    rl <= 1;
    walm(8'h63);
    {rl, hm} <= 0;
    clear;
    ahb(1, 8'h00, 32'h0000_00C0);
    {hm, hs, sa} <= 3'b111;
    chk <= 1;
    tick;
    chk <= 0;
    walm(8'h64);
    clear;
    ahb(1, 8'h00, 32'h0000_0080);
    chk <= 1;
    tick;
    chk <= 0;
    repeat (3) tick;
    cmp(alm, 0);
    {hm, hs, sa} <= 0;
    $display("test homing done");
    ahb(1, 8'h00, 0);
    {ofs, fl} <= 2'b11;
    walm(8'h6A);
    {ofs, fl} <= 0;
    clear;
    spd <= 5;
    sds <= 1;
    tick;
    sds <= 0;
    repeat (3) tick;
    cmp(alm, 0);
    spd <= 0;
    sds <= 1;
    tick;
    sds <= 0;
    walm(8'h70);
    rd(8'h14, 32'h0001_0370);
    clear;
    cmp(alm, 0);
    $display("test data done");
    ahb(1, 8'h20, 4);
    frame(2);
    cmp(irq, 1);
    ahb(1, 8'h1C, 7);
    cmp(irq, 0);
    ahb(1, 8'h20, 0);
    frame(2);
    frame(1);
    frame(2);
    frame(2);
    cmp(alm, 0);
    frame(2);
    walm(8'h84);
    cmp(irq, 0);
    rd(8'h18, 32'h0000_0005);
    clear;
    ahb(1, 8'h10, 30);
    frame(1);
    repeat (15) tick;
    cmp(alm, 0);
    walm(8'h85);
    ahb(1, 8'h10, 0);
    clear;
    cmp(alm, 0);
    $display("test link done");
    cpu <= 1;
    tick;
    cpu <= 0;
    walm(8'hF0);
    cmp(exc, 0);
    clear;
    cmp({alm, code, led}, 10'h3E1);
    rst_n <= 0;
    repeat (2) tick;
    rst_n <= 1;
    tick;
    cmp({alm, exc, code}, 10'h100);
    $display("test fault done");
    end_sim;
  end
endmodule
